// *** verilog/frame_fmt_params.svh ***
// Offsets, field positions, reset values and check code polynomial of the frame formatter
`ifndef FRAME_FMT_PARAMS_SVH
`define FRAME_FMT_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL     12'h000
`define OFS_WIN0     12'h004
`define OFS_WIN1     12'h008
`define OFS_GEOM     12'h00c
`define OFS_TIME     12'h010
`define OFS_TRAIN    12'h014
`define OFS_STATUS   12'h018

// Control field positions
`define CTRL_RUN     0
`define CTRL_W1EN    1
`define CTRL_SUB_LO  2
`define CTRL_BFEN    4
`define CTRL_BREN    5
`define CTRL_SEED    6

// Other field positions
`define WIN_FIRST_LO 0
`define WIN_LAST_LO  16
`define GEOM_KERN_LO 0
`define GEOM_BLK_LO  8
`define TIME_FOT_LO  0
`define TIME_ROT_LO  16

// Reset values
`define RST_CTRL     32'h0000_0000
`define RST_WIN      32'h03ff_0000
`define RST_GEOM     32'h0000_08a0
`define RST_TIME     32'h0010_0020
`define RST_TRAIN    32'h0000_03a6

// Check code polynomial, ten bits below the top term
`define CRC_POLY     10'h24f

`endif

// *** verilog/frame_fmt_pkg.sv ***
// Types shared by the frame formatter modules
package frame_fmt_pkg;

  typedef enum logic [5:0] {
    st_idle = 6'h01,
    st_fot  = 6'h02,
    st_scan = 6'h04,
    st_row  = 6'h08,
    st_crc  = 6'h10,
    st_rot  = 6'h20
  } fmt_state_t;

  typedef enum logic [1:0] {
    sub_none  = 2'h0,
    sub_mono  = 2'h1,
    sub_color = 2'h2
  } sub_mode_t;

  typedef enum logic [1:0] {
    kind_idle = 2'h0,
    kind_pix  = 2'h1,
    kind_crc  = 2'h2
  } slot_kind_t;

endpackage

// *** verilog/order_if.sv ***
// Link between the frame sequencer and the kernel pixel orderer
`timescale 1ns/1ns
interface order_if;
  logic [1:0]  mode;
  logic [7:0]  kernels;
  logic        restart;
  logic        step;
  logic [10:0] col;
  logic        last;

  modport seq (input mode, kernels, restart, step, output col, last);
  modport ctl (output mode, kernels, restart, step, input col, last);
endinterface

// *** verilog/kernel_order.sv ***
// Column sequence of one row in eight-pixel kernels
`timescale 1ns/1ns
module kernel_order (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Sequencer link
  order_if.seq     ord
);

  logic [7:0]  kcnt_r;
  logic [7:0]  kcnt_nxt;
  logic [2:0]  stp_r;
  logic [2:0]  stp_nxt;
  logic [7:0]  limit;
  logic [11:0] col_w;

  // Kernel and step counters
  always_comb begin
    kcnt_nxt = kcnt_r;
    stp_nxt  = stp_r;
    if (ord.restart) begin
      kcnt_nxt = 8'h00;
      stp_nxt  = 3'h0;
    end else if (ord.step) begin
      stp_nxt = stp_r + 3'h1;
      if (stp_r == 3'h7) begin
        kcnt_nxt = kcnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      kcnt_r <= 8'h00;
      stp_r  <= 3'h0;
    end else begin
      kcnt_r <= kcnt_nxt;
      stp_r  <= stp_nxt;
    end
  end

  // Column of the current step for each mode
  always_comb begin
    case (ord.mode)
      frame_fmt_pkg::sub_mono: begin
        col_w = {kcnt_r, 4'h0} + {8'h00, stp_r, 1'b0};
        limit = {1'b0, ord.kernels[7:1]};
      end
      frame_fmt_pkg::sub_color: begin
        col_w = {kcnt_r, 4'h0} + {8'h00, stp_r[2:1], 2'h0}
              + {11'h000, stp_r[0]};
        limit = {1'b0, ord.kernels[7:1]};
      end
      default: begin
        col_w = {1'b0, kcnt_r, 3'h0}
              + {9'h000, (kcnt_r[0] ? ~stp_r : stp_r)};
        limit = ord.kernels;
      end
    endcase
  end

  assign ord.col  = col_w[10:0];
  assign ord.last = (stp_r == 3'h7) && ({1'b0, kcnt_r} + 9'h001
                    >= {1'b0, limit});
endmodule

// *** verilog/frame_formatter.sv ***
// Parallel pixel frame formatter with APB configuration
`timescale 1ns/1ns
`include "frame_fmt_params.svh"
module frame_formatter (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link clock from outside
  input  wire logic        link_clk,
  // Pixel source
  output logic             pix_rd_en,
  output logic      [9:0]  pix_rd_row,
  output logic      [10:0] pix_rd_col,
  output logic             pix_rd_black,
  input  wire logic [9:0]  pix_value,
  // Parallel output
  output logic             pix_clk_out,
  output logic             frame_active,
  output logic             row_active,
  output logic      [9:0]  pix_data
);

  order_if ord ();

  logic lclk_s1_r;
  logic lclk_s2_r;
  logic lclk_s3_r;
  logic pix_en;

  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] win0_r, win0_nxt;
  logic [31:0] win1_r, win1_nxt;
  logic [31:0] geom_r, geom_nxt;
  logic [31:0] time_r, time_nxt;
  logic [31:0] train_r, train_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [31:0] rd_val;
  logic        hit;

  frame_fmt_pkg::fmt_state_t state_r, state_nxt;
  frame_fmt_pkg::slot_kind_t kind_r, kind_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [9:0]  row_r, row_nxt;
  logic [7:0]  brow_r, brow_nxt;
  logic        black_r, black_nxt;
  logic        fon_r, fon_nxt;
  logic        fa_r, fa_nxt;
  logic        la_r, la_nxt;
  logic [15:0] frames_r, frames_nxt;
  logic        rd_en_r, rd_en_nxt;
  logic [9:0]  rd_row_r, rd_row_nxt;
  logic [10:0] rd_col_r, rd_col_nxt;
  logic        rd_blk_r, rd_blk_nxt;
  logic        ord_restart;
  logic        ord_step;

  logic [9:0]  crc_r, crc_nxt;
  logic [9:0]  data_r, data_nxt;
  logic        fv_r, fv_nxt;
  logic        lv_r, lv_nxt;
  logic        pclk_r;

  logic [9:0]  w0f, w0l, w1f, w1l, lo, hi;
  logic [7:0]  nblack;
  logic [15:0] frame_overhead_time, row_overhead_time;
  logic        w1en, bfen, bren, included, blk_more;

  // Link clock synchroniser and slot enable on its rising edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lclk_s1_r <= 1'b0;
      lclk_s2_r <= 1'b0;
      lclk_s3_r <= 1'b0;
    end else begin
      lclk_s1_r <= link_clk;
      lclk_s2_r <= lclk_s1_r;
      lclk_s3_r <= lclk_s2_r;
    end
  end
  assign pix_en = lclk_s2_r & ~lclk_s3_r;

  // Configuration fields
  assign w0f    = win0_r[`WIN_FIRST_LO +: 10];
  assign w0l    = win0_r[`WIN_LAST_LO +: 10];
  assign w1f    = win1_r[`WIN_FIRST_LO +: 10];
  assign w1l    = win1_r[`WIN_LAST_LO +: 10];
  assign w1en   = ctrl_r[`CTRL_W1EN];
  assign bfen   = ctrl_r[`CTRL_BFEN];
  assign bren   = ctrl_r[`CTRL_BREN];
  assign nblack = geom_r[`GEOM_BLK_LO +: 8];
  assign frame_overhead_time    = time_r[`TIME_FOT_LO +: 16];
  assign row_overhead_time    = time_r[`TIME_ROT_LO +: 16];

  // Row span and membership of the window union
  assign lo = (w1en && w1f < w0f) ? w1f : w0f;
  assign hi = (w1en && w1l > w0l) ? w1l : w0l;
  assign included = (row_r >= w0f && row_r <= w0l)
                 || (w1en && row_r >= w1f && row_r <= w1l);
  assign blk_more = ({1'b0, brow_r} + 9'h001) < {1'b0, nblack};

  // APB decode and read mux
  always_comb begin
    hit = 1'b1;
    case (paddr)
      `OFS_CTRL:   rd_val = ctrl_r;
      `OFS_WIN0:   rd_val = win0_r;
      `OFS_WIN1:   rd_val = win1_r;
      `OFS_GEOM:   rd_val = geom_r;
      `OFS_TIME:   rd_val = time_r;
      `OFS_TRAIN:  rd_val = train_r;
      `OFS_STATUS: rd_val = {frames_r, 3'h0, row_r, black_r, fon_r,
                             (state_r != frame_fmt_pkg::st_idle)};
      default: begin
        rd_val = 32'h0000_0000;
        hit    = 1'b0;
      end
    endcase
  end

  // Register writes in the access phase, read data latched in setup
  always_comb begin
    ctrl_nxt   = ctrl_r;
    win0_nxt   = win0_r;
    win1_nxt   = win1_r;
    geom_nxt   = geom_r;
    time_nxt   = time_r;
    train_nxt  = train_r;
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      prdata_nxt = rd_val;
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        `OFS_CTRL:  ctrl_nxt  = {25'h0000000, pwdata[6:0]};
        `OFS_WIN0:  win0_nxt  = {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
        `OFS_WIN1:  win1_nxt  = {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
        `OFS_GEOM:  geom_nxt  = {16'h0000, pwdata[15:0]};
        `OFS_TIME:  time_nxt  = pwdata;
        `OFS_TRAIN: train_nxt = {22'h000000, pwdata[9:0]};
        default:    ctrl_nxt  = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r   <= `RST_CTRL;
      win0_r   <= `RST_WIN;
      win1_r   <= `RST_WIN;
      geom_r   <= `RST_GEOM;
      time_r   <= `RST_TIME;
      train_r  <= `RST_TRAIN;
      prdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      win0_r   <= win0_nxt;
      win1_r   <= win1_nxt;
      geom_r   <= geom_nxt;
      time_r   <= time_nxt;
      train_r  <= train_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Frame sequencer: overhead, row scan, pixels, check code
  always_comb begin
    state_nxt   = state_r;
    kind_nxt    = kind_r;
    cnt_nxt     = cnt_r;
    row_nxt     = row_r;
    brow_nxt    = brow_r;
    black_nxt   = black_r;
    fon_nxt     = fon_r;
    fa_nxt      = fa_r;
    la_nxt      = la_r;
    frames_nxt  = frames_r;
    rd_en_nxt   = 1'b0;
    rd_row_nxt  = rd_row_r;
    rd_col_nxt  = rd_col_r;
    rd_blk_nxt  = rd_blk_r;
    ord_restart = 1'b0;
    ord_step    = 1'b0;
    if (pix_en) begin
      kind_nxt = frame_fmt_pkg::kind_idle;
      fa_nxt   = fon_r;
      la_nxt   = 1'b0;
    end
    case (state_r)
      frame_fmt_pkg::st_idle: begin
        if (pix_en && ctrl_r[`CTRL_RUN]) begin
          state_nxt = frame_fmt_pkg::st_fot;
          cnt_nxt   = frame_overhead_time;
        end
      end
      frame_fmt_pkg::st_fot: begin
        if (pix_en) begin
          cnt_nxt = cnt_r - 16'h0001;
          if (cnt_r <= 16'h0001) begin
            brow_nxt = 8'h00;
            if (nblack != 8'h00) begin
              black_nxt   = 1'b1;
              state_nxt   = frame_fmt_pkg::st_row;
              ord_restart = 1'b1;
              fon_nxt     = bfen;
            end else begin
              black_nxt = 1'b0;
              row_nxt   = lo;
              state_nxt = frame_fmt_pkg::st_scan;
            end
          end
        end
      end
      frame_fmt_pkg::st_scan: begin
        if (row_r > hi) begin
          state_nxt  = frame_fmt_pkg::st_idle;
          fon_nxt    = 1'b0;
          frames_nxt = frames_r + 16'h0001;
        end else if (included) begin
          state_nxt   = frame_fmt_pkg::st_row;
          ord_restart = 1'b1;
          fon_nxt     = 1'b1;
        end else begin
          row_nxt = row_r + 10'h001;
        end
      end
      frame_fmt_pkg::st_row: begin
        if (pix_en) begin
          kind_nxt   = frame_fmt_pkg::kind_pix;
          la_nxt     = black_r ? bren : 1'b1;
          rd_en_nxt  = 1'b1;
          rd_row_nxt = black_r ? {2'h0, brow_r} : row_r;
          rd_col_nxt = ord.col;
          rd_blk_nxt = black_r;
          ord_step   = 1'b1;
          if (ord.last) begin
            state_nxt = frame_fmt_pkg::st_crc;
          end
        end
      end
      frame_fmt_pkg::st_crc: begin
        if (pix_en) begin
          kind_nxt = frame_fmt_pkg::kind_crc;
          if (black_r || row_r < hi) begin
            state_nxt = frame_fmt_pkg::st_rot;
            cnt_nxt   = row_overhead_time;
          end else begin
            state_nxt  = frame_fmt_pkg::st_idle;
            fon_nxt    = 1'b0;
            frames_nxt = frames_r + 16'h0001;
          end
        end
      end
      frame_fmt_pkg::st_rot: begin
        if (pix_en) begin
          cnt_nxt = cnt_r - 16'h0001;
          if (cnt_r <= 16'h0001) begin
            if (black_r && blk_more) begin
              brow_nxt    = brow_r + 8'h01;
              state_nxt   = frame_fmt_pkg::st_row;
              ord_restart = 1'b1;
            end else begin
              black_nxt = 1'b0;
              row_nxt   = black_r ? lo : row_r + 10'h001;
              state_nxt = frame_fmt_pkg::st_scan;
            end
          end
        end
      end
      default: begin
        state_nxt = frame_fmt_pkg::st_idle;
        fon_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r  <= frame_fmt_pkg::st_idle;
      kind_r   <= frame_fmt_pkg::kind_idle;
      cnt_r    <= 16'h0000;
      row_r    <= 10'h000;
      brow_r   <= 8'h00;
      black_r  <= 1'b0;
      fon_r    <= 1'b0;
      fa_r     <= 1'b0;
      la_r     <= 1'b0;
      frames_r <= 16'h0000;
      rd_en_r  <= 1'b0;
      rd_row_r <= 10'h000;
      rd_col_r <= 11'h000;
      rd_blk_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      kind_r   <= kind_nxt;
      cnt_r    <= cnt_nxt;
      row_r    <= row_nxt;
      brow_r   <= brow_nxt;
      black_r  <= black_nxt;
      fon_r    <= fon_nxt;
      fa_r     <= fa_nxt;
      la_r     <= la_nxt;
      frames_r <= frames_nxt;
      rd_en_r  <= rd_en_nxt;
      rd_row_r <= rd_row_nxt;
      rd_col_r <= rd_col_nxt;
      rd_blk_r <= rd_blk_nxt;
    end
  end

  assign pix_rd_en    = rd_en_r;
  assign pix_rd_row   = rd_row_r;
  assign pix_rd_col   = rd_col_r;
  assign pix_rd_black = rd_blk_r;

  assign ord.mode    = ctrl_r[`CTRL_SUB_LO +: 2];
  assign ord.kernels = geom_r[`GEOM_KERN_LO +: 8];
  assign ord.restart = ord_restart;
  assign ord.step    = ord_step;

  kernel_order u_order (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ord     (ord)
  );

  // One step of the row check code over a ten-bit word, MSB first
  function automatic logic [9:0] crc_step(input logic [9:0] c,
                                          input logic [9:0] d);
    logic [9:0] v;
    logic       fb;
    v = c;
    for (int i = 9; i >= 0; i--) begin
      fb = v[9] ^ d[i];
      v  = {v[8:0], 1'b0} ^ (fb ? `CRC_POLY : 10'h000);
    end
    return v;
  endfunction

  // Output stage: pixel word, check code or training word per slot
  always_comb begin
    data_nxt = data_r;
    fv_nxt   = fv_r;
    lv_nxt   = lv_r;
    crc_nxt  = crc_r;
    if (pix_en) begin
      fv_nxt = fa_r;
      lv_nxt = la_r;
      case (kind_r)
        frame_fmt_pkg::kind_pix: begin
          data_nxt = pix_value;
          crc_nxt  = crc_step(crc_r, pix_value);
        end
        frame_fmt_pkg::kind_crc: begin
          data_nxt = crc_r;
          crc_nxt  = {10{ctrl_r[`CTRL_SEED]}};
        end
        default: begin
          data_nxt = train_r[9:0];
          crc_nxt  = crc_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      data_r <= 10'h3a6;
      fv_r   <= 1'b0;
      lv_r   <= 1'b0;
      crc_r  <= 10'h000;
      pclk_r <= 1'b0;
    end else begin
      data_r <= data_nxt;
      fv_r   <= fv_nxt;
      lv_r   <= lv_nxt;
      crc_r  <= crc_nxt;
      pclk_r <= ~lclk_s3_r;  // Rises five clocks after data changes
    end
  end

  assign pix_data     = data_r;
  assign frame_active = fv_r;
  assign row_active   = lv_r;
  assign pix_clk_out  = pclk_r;
endmodule

// *** bench/frame_formatter_monitor.sv ***
// Port checker of the frame formatter, bound to its top module
`timescale 1ns/1ns
module frame_formatter_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pixel side
  input wire logic        pix_rd_en,
  input wire logic        pix_clk_out,
  input wire logic        frame_active,
  input wire logic        row_active,
  input wire logic [9:0]  pix_data
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Bus answers: ready in every access, error only off the map
  ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  hole_error_a: assert property (psel && penable && paddr > 12'h018 |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (psel && penable && paddr <= 12'h018 &&
    paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access flagged");
  // One request pulse per slot of eight clocks
  rd_pulse_a: assert property (pix_rd_en |=> !pix_rd_en [*6])
    else $error("pixel request too long or too close");
  // A row or frame opens with the word asked for one slot earlier
  row_rise_a: assert property ($rose(row_active) |-> $past(pix_rd_en, 8))
    else $error("row strobe without a pixel behind it");
  frame_rise_a: assert property ($rose(frame_active) |->
    $past(pix_rd_en, 8)) else $error("frame strobe opens without a pixel");
  // Frame closes one slot after the code word of the last row
  frame_fall_a: assert property ($fell(frame_active) |->
    !row_active && $past(row_active, 12))
    else $error("frame strobe falls out of place");
  // Strobe and pixel words stand for a whole slot
  row_hold_a: assert property ($rose(row_active) |=> row_active [*6])
    else $error("row strobe shorter than a slot");
  word_stand_a: assert property (row_active && $changed(pix_data) |=>
    $stable(pix_data) [*6]) else $error("pixel word not held a slot");
  clk_mid_a: assert property ($rose(pix_clk_out) |->
    $stable(pix_data) ##1 $stable(pix_data))
    else $error("output clock edge near a data change");
endmodule

bind frame_formatter frame_formatter_monitor mon (
  .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .pix_rd_en(pix_rd_en),
  .pix_clk_out(pix_clk_out), .frame_active(frame_active),
  .row_active(row_active), .pix_data(pix_data)
);

// *** bench/pixel_far_model.sv ***
// Far side model: pixel core answering requests and a capture receiver
`timescale 1ns/1ns
module pixel_far_model (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // Pixel requests
  input wire logic        pix_rd_en,
  input wire logic [9:0]  pix_rd_row,
  input wire logic [10:0] pix_rd_col,
  input wire logic        pix_rd_black,
  output logic     [9:0]  pix_value,
  // Parallel output
  input wire logic        pix_clk_out,
  input wire logic        frame_active,
  input wire logic        row_active,
  input wire logic [9:0]  pix_data
);
  logic [11:0] words[$];

  // Core answers each request with marker, kind, row and column
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pix_value <= 10'h000;
    end else if (pix_rd_en) begin
      pix_value <= {1'b1, pix_rd_black, pix_rd_row[2:0], pix_rd_col[4:0]};
    end
  end

  // Receiver keeps every nonzero word with both strobes
  always @(posedge pix_clk_out) begin
    if (pix_data !== 10'h000) begin
      words.push_back({frame_active, row_active, pix_data});
    end
  end
endmodule

// *** bench/tb.sv ***
// Testbench of the frame formatter: registers, then four formatted frames
`timescale 1ns/1ns
`include "frame_fmt_params.svh"
module tb;
  logic        mclk, reset_n, psel, penable, pwrite, link_clk, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pix_rd_en, pix_rd_black, pix_clk_out;
  logic        frame_active, row_active;
  logic [9:0]  pix_rd_row, pix_value, pix_data;
  logic [10:0] pix_rd_col;
  int          mismatches, num_checks, cycles;
  logic        last_seed = 1'b0;  // Seed left behind by the last code word
  logic [11:0] ofs[6] = '{`OFS_CTRL, `OFS_WIN0, `OFS_WIN1, `OFS_GEOM,
                          `OFS_TIME, `OFS_TRAIN};
  logic [31:0] rstv[6] = '{`RST_CTRL, `RST_WIN, `RST_WIN, `RST_GEOM,
                           `RST_TIME, `RST_TRAIN};
  logic [31:0] cfg[6] = '{32'h0, 32'h0004_0002, 32'h0006_0003,
                          32'h0000_0204, 32'h0002_0002, 32'h0};

  frame_formatter dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .pix_rd_en(pix_rd_en), .pix_rd_row(pix_rd_row),
    .pix_rd_col(pix_rd_col), .pix_rd_black(pix_rd_black),
    .pix_value(pix_value), .pix_clk_out(pix_clk_out),
    .frame_active(frame_active), .row_active(row_active),
    .pix_data(pix_data));
  pixel_far_model far (.mclk(mclk), .reset_n(reset_n),
    .pix_rd_en(pix_rd_en), .pix_rd_row(pix_rd_row), .pix_rd_col(pix_rd_col),
    .pix_rd_black(pix_rd_black), .pix_value(pix_value),
    .pix_clk_out(pix_clk_out), .frame_active(frame_active),
    .row_active(row_active), .pix_data(pix_data));

  // System clock and a link clock of unrelated phase
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end

  task automatic check(input string what, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer: setup, then access until ready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                      input logic experr);
    apb(1'b0, a, 32'h0, rd, err);
    check("read data", rd, exp);
    check("slave error", {31'h0, err}, {31'h0, experr});
  endtask

  task automatic wait_fa(input logic lv);
    int n;
    n = 0;
    while (frame_active !== lv && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20000) mismatches++;
  endtask

  // Column of the i-th word of a row for each readout order
  function automatic logic [4:0] colf(input int i, input logic [1:0] sub);
    int k, j;
    k = i / 8;
    j = i % 8;
    if (sub == frame_fmt_pkg::sub_mono) return 5'(16 * k + 2 * j);
    if (sub == frame_fmt_pkg::sub_color) return 5'(16 * k + 4 * (j / 2) + j % 2);
    return (k % 2 == 0) ? 5'(8 * k + j) : 5'(8 * k + 7 - j);
  endfunction

  // Check code update, one ten-bit word, top bit first
  function automatic logic [9:0] crc_step(input logic [9:0] c, d);
    logic fb;
    for (int b = 9; b >= 0; b--) begin
      fb = c[9] ^ d[b];
      c = {c[8:0], 1'b0} ^ (fb ? `CRC_POLY : 10'h000);
    end
    return c;
  endfunction

  // Run one frame: 2 black rows, image rows 2..6 from two windows
  task automatic run_frame(input logic [1:0] sub, input logic bf, br, sd);
    logic [11:0] exp[$];
    logic [9:0]  c, v;
    logic        blk, fexp, rexp;
    logic [31:0] ctl;
    int          n;
    ctl = {25'h0, sd, br, bf, sub, 2'h3};
    far.words.delete();
    apb(1'b1, `OFS_CTRL, ctl, rd, err);
    wait_fa(1'b1);
    apb(1'b1, `OFS_CTRL, ctl & 32'hffff_fffe, rd, err);
    wait_fa(1'b0);
    repeat (40) @(posedge mclk);
    n = (sub == frame_fmt_pkg::sub_none) ? 32 : 16;
    for (int row = 0; row < 7; row++) begin
      blk = (row < 2);
      fexp = blk ? bf : 1'b1;
      rexp = blk ? br : 1'b1;
      c = (row == 0) ? {10{last_seed}} : {10{sd}};
      for (int i = 0; i < n; i++) begin
        v = {1'b1, blk, 3'(row), colf(i, sub)};
        c = crc_step(c, v);
        exp.push_back({fexp, rexp, v});
      end
      exp.push_back({fexp, 1'b0, c});
    end
    last_seed = sd;
    check("word count", far.words.size(), exp.size());
    foreach (exp[i]) begin
      if (i < far.words.size()) begin
        check("frame word", far.words[i], exp[i]);
      end
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks made %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Ceiling on run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values, then configuration written and read back
    foreach (ofs[i]) rchk(ofs[i], rstv[i], 1'b0);
    for (int i = 1; i < 6; i++) begin
      apb(1'b1, ofs[i], cfg[i], rd, err);
      rchk(ofs[i], cfg[i], 1'b0);
    end
    // Read-only status and an unmapped word
    apb(1'b1, `OFS_STATUS, 32'hffff_ffff, rd, err);
    rchk(`OFS_STATUS, 32'h0, 1'b0);
    apb(1'b1, 12'h01c, 32'h1234_5678, rd, err);
    check("write error", {31'h0, err}, 32'h1);
    rchk(12'h01c, 32'h0, 1'b1);
    // Every readout order and every black-row strobe setting
    run_frame(frame_fmt_pkg::sub_none, 1'b1, 1'b1, 1'b0);
    run_frame(frame_fmt_pkg::sub_mono, 1'b1, 1'b0, 1'b0);
    run_frame(frame_fmt_pkg::sub_color, 1'b0, 1'b1, 1'b0);
    run_frame(frame_fmt_pkg::sub_none, 1'b0, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule
